// ==== design/dsp_pkg.sv ====
package dsp_pkg;

	// ==========================================================
	// Data widths
	localparam int A_W    = 30;
	localparam int B_W    = 18;
	localparam int C_W    = 48;
	localparam int D_W    = 25;
	localparam int MA_W   = 27;
	localparam int PROD_W = 45;
	localparam int LANES  = 4;
	localparam int LANE_W = 12;

	// ==========================================================
	// Consolidated 20-bit control word, bit 0 is opmode[0]
	typedef struct packed {
		logic [4:0] inmode;
		logic [2:0] carry_sel;
		logic       carry_in;
		logic [3:0] alu_fn;
		logic [6:0] opmode;
	} dsp_ctrl_t;

	typedef struct packed {
		logic a;
		logic b;
		logic c;
		logic m;
		logic p;
		logic carry;
		logic alu;
		logic ctrl;
		logic d;
		logic inmode;
	} dsp_clr_t;

	typedef struct packed {
		logic a_first_stage_enable;
		logic a_second_stage_enable;
		logic b_first_stage_enable;
		logic b_second_stage_enable;
		logic c;
		logic m;
		logic p;
		logic carry;
		logic alu;
		logic ctrl;
		logic d;
		logic ad;
		logic inmode;
	} dsp_ce_t;

	typedef enum {SIMD_ONE48, SIMD_TWO24, SIMD_FOUR12} dsp_simd_t;
	typedef enum {MASK_ATTR, MASK_C, MASK_ROUND1, MASK_ROUND2}
		dsp_mask_src_t;

	// ==========================================================
	// Operation codes
	localparam logic [1:0] X_PROD        = 2'h1;
	localparam logic [1:0] X_P           = 2'h2;
	localparam logic [1:0] X_AB          = 2'h3;
	localparam logic [1:0] Y_C           = 2'h3;
	localparam logic [2:0] Z_PCIN        = 3'h1;
	localparam logic [2:0] Z_P           = 3'h2;
	localparam logic [2:0] Z_C           = 3'h3;
	localparam logic [3:0] ALU_ADD       = 4'h0;
	localparam logic [3:0] ALU_SUB       = 4'h3;
	localparam logic [3:0] ALU_XOR       = 4'h4;
	localparam logic [3:0] ALU_AND       = 4'hc;
	localparam logic [3:0] ALU_OR        = 4'he;
	localparam logic [2:0] CSEL_CARRY_IN = 3'h0;
	localparam int         PREADD_BIT    = 3;

	// Lane start and lane end masks per SIMD mode
	localparam logic [3:0] BRK_ONE48  = 4'h1;
	localparam logic [3:0] BRK_TWO24  = 4'h5;
	localparam logic [3:0] BRK_FOUR12 = 4'hf;
	localparam logic [3:0] END_ONE48  = 4'h8;
	localparam logic [3:0] END_TWO24  = 4'ha;
	localparam logic [3:0] END_FOUR12 = 4'hf;

	// ==========================================================
	// Wishbone register map
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam int         CTL_AUTO   = 0;
	localparam int         CTL_PRIO   = 1;
	localparam int         CTL_AMUX   = 2;
	localparam int         CTL_BMUX   = 3;
	localparam int         CTL_PRESEL = 4;
	localparam int         CTL_W      = 5;
	localparam logic [4:0] CTL_RST    = 5'h00;
	localparam int         ST_PD      = 0;
	localparam int         ST_PBD     = 1;
	localparam int         ST_MISUSE  = 2;

endpackage

// ==== design/dsp_pipe.sv ====
`timescale 1ns/100ps
module dsp_pipe
	import dsp_pkg::*;
#(
	parameter int W     = 1,
	parameter int DEPTH = 1,
	parameter int TAP   = 0
)
(
	input  wire logic         clk_i,
	input  wire logic         clr_i,
	input  wire logic [1:0]   ce_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o,
	output logic      [W-1:0] tap_o
);

	// ==========================================================
	// Stage chain; index 0 is the unregistered input
	logic [DEPTH:0][W-1:0] stage;

	if (DEPTH < 0 || DEPTH > 2 || TAP < 0 || TAP > DEPTH)
	begin : g_bad_depth
		$error("pipeline depth or tap out of range");
	end

	assign stage[0] = d_i;

	// Depth zero builds no flop at all
	for (genvar i = 1; i <= DEPTH; i++)
	begin : g_stage
		always_ff @(posedge clk_i)
		begin
			if (clr_i)
				stage[i] <= '0;
			else if (ce_i[i-1])
				stage[i] <= stage[i-1];
		end
	end

	assign q_o   = stage[DEPTH];
	assign tap_o = stage[TAP];

endmodule

// ==== design/dsp_slice.sv ====
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/100ps
module dsp_slice
	import dsp_pkg::*;
#(
	parameter int            A_DEPTH      = 1,
	parameter int            B_DEPTH      = 1,
	parameter int            ACOUT_DEPTH  = 1,
	parameter int            BCOUT_DEPTH  = 1,
	parameter int            C_DEPTH      = 1,
	parameter int            M_DEPTH      = 1,
	parameter int            P_DEPTH      = 1,
	parameter int            OPMODE_DEPTH = 1,
	parameter int            ALU_DEPTH    = 1,
	parameter int            CARRY_DEPTH  = 1,
	parameter int            CSEL_DEPTH   = 1,
	parameter int            D_DEPTH      = 1,
	parameter int            AD_DEPTH     = 1,
	parameter int            INMODE_DEPTH = 1,
	parameter bit            USE_MULT     = 1'b1,
	parameter dsp_simd_t     SIMD         = SIMD_ONE48,
	parameter bit            PAT_FROM_C   = 1'b0,
	parameter dsp_mask_src_t MASK_SRC     = MASK_ATTR,
	parameter logic [47:0]   PATTERN      = 48'h0000_0000_0000,
	parameter logic [47:0]   MASK         = 48'h0000_0000_0000
)
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [29:0] a_i,
	input  wire logic [17:0] b_i,
	input  wire logic [47:0] c_i,
	input  wire logic [24:0] d_i,
	input  wire logic [47:0] pcin_i,
	input  wire dsp_ctrl_t   ctrl_i,
	input  wire dsp_clr_t    clr_i,
	input  wire dsp_ce_t     ce_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic      [47:0] p_o,
	output logic      [47:0] pcout_o,
	output logic      [29:0] acout_o,
	output logic      [17:0] bcout_o,
	output logic      [3:0]  carry_out_o,
	output logic             pattern_detect_o,
	output logic             pattern_bar_detect_o,
	output logic             mult_misuse_o
);

	// ==========================================================
	// Configuration checks
	if (BCOUT_DEPTH > B_DEPTH || ACOUT_DEPTH > A_DEPTH)
	begin : g_bad_cascade
		$error("cascade-out depth exceeds operand depth");
	end
	if (C_DEPTH > 1 || M_DEPTH > 1 || P_DEPTH > 1 || OPMODE_DEPTH > 1 ||
		ALU_DEPTH > 1 || CARRY_DEPTH > 1 || CSEL_DEPTH > 1 ||
		D_DEPTH > 1 || AD_DEPTH > 1 || INMODE_DEPTH > 1)
	begin : g_bad_single
		$error("single-stage register depth above one");
	end

	localparam logic [3:0] BRK = (SIMD == SIMD_TWO24) ? BRK_TWO24 :
		(SIMD == SIMD_FOUR12) ? BRK_FOUR12 : BRK_ONE48;
	localparam logic [3:0] ENDS = (SIMD == SIMD_TWO24) ? END_TWO24 :
		(SIMD == SIMD_FOUR12) ? END_FOUR12 : END_ONE48;

	logic [29:0]       a_q;
	logic [17:0]       b_q;
	logic [47:0]       c_q;
	logic [24:0]       d_q;
	logic [26:0]       ad_q;
	logic [26:0]       next_ad;
	logic [4:0]        inmode_q;
	logic [6:0]        opmode_q;
	logic [3:0]        alu_q;
	logic              carry_q;
	logic [2:0]        csel_q;
	logic [PROD_W-1:0] m_q;
	logic [PROD_W-1:0] next_m;
	logic [26:0]       mult_a;
	logic [17:0]       mult_b;
	logic [26:0]       pre_op;
	logic [47:0]       x_op;
	logic [47:0]       y_op;
	logic [47:0]       z_op;
	logic              cin;
	logic [51:0]       xy;
	logic [51:0]       res;
	logic [47:0]       pat;
	logic [47:0]       mask;
	logic [53:0]       next_p;
	logic [53:0]       p_grp;
	logic              auto_clr;
	logic [CTL_W-1:0]  ctl;

	// ==========================================================
	// Operand pipelines
	dsp_pipe #(.W(A_W), .DEPTH(A_DEPTH), .TAP(ACOUT_DEPTH)) u_a
	(
		.clk_i (clk_i),
		.clr_i (rst_i | clr_i.a),
		.ce_i  ({ce_i.a_second_stage_enable,
			ce_i.a_first_stage_enable}),
		.d_i   (a_i),
		.q_o   (a_q),
		.tap_o (acout_o)
	);

	dsp_pipe #(.W(B_W), .DEPTH(B_DEPTH), .TAP(BCOUT_DEPTH)) u_b
	(
		.clk_i (clk_i),
		.clr_i (rst_i | clr_i.b),
		.ce_i  ({ce_i.b_second_stage_enable,
			ce_i.b_first_stage_enable}),
		.d_i   (b_i),
		.q_o   (b_q),
		.tap_o (bcout_o)
	);

	dsp_pipe #(.W(C_W), .DEPTH(C_DEPTH)) u_c
	(
		.clk_i (clk_i),
		.clr_i (rst_i | clr_i.c),
		.ce_i  ({1'b0, ce_i.c}),
		.d_i   (c_i),
		.q_o   (c_q),
		.tap_o ()
	);

	dsp_pipe #(.W(D_W), .DEPTH(D_DEPTH)) u_d
	(
		.clk_i (clk_i),
		.clr_i (rst_i | clr_i.d),
		.ce_i  ({1'b0, ce_i.d}),
		.d_i   (d_i),
		.q_o   (d_q),
		.tap_o ()
	);

	// ==========================================================
	// Control pipelines
	dsp_pipe #(.W(5), .DEPTH(INMODE_DEPTH)) u_inmode
	(
		.clk_i (clk_i),
		.clr_i (rst_i | clr_i.inmode),
		.ce_i  ({1'b0, ce_i.inmode}),
		.d_i   (ctrl_i.inmode),
		.q_o   (inmode_q),
		.tap_o ()
	);

	dsp_pipe #(.W(7), .DEPTH(OPMODE_DEPTH)) u_opmode
	(
		.clk_i (clk_i),
		.clr_i (rst_i | clr_i.ctrl),
		.ce_i  ({1'b0, ce_i.ctrl}),
		.d_i   (ctrl_i.opmode),
		.q_o   (opmode_q),
		.tap_o ()
	);

	dsp_pipe #(.W(3), .DEPTH(CSEL_DEPTH)) u_csel
	(
		.clk_i (clk_i),
		.clr_i (rst_i | clr_i.ctrl),
		.ce_i  ({1'b0, ce_i.ctrl}),
		.d_i   (ctrl_i.carry_sel),
		.q_o   (csel_q),
		.tap_o ()
	);

	dsp_pipe #(.W(4), .DEPTH(ALU_DEPTH)) u_alu
	(
		.clk_i (clk_i),
		.clr_i (rst_i | clr_i.alu),
		.ce_i  ({1'b0, ce_i.alu}),
		.d_i   (ctrl_i.alu_fn),
		.q_o   (alu_q),
		.tap_o ()
	);

	dsp_pipe #(.W(1), .DEPTH(CARRY_DEPTH)) u_carry
	(
		.clk_i (clk_i),
		.clr_i (rst_i | clr_i.carry),
		.ce_i  ({1'b0, ce_i.carry}),
		.d_i   (ctrl_i.carry_in),
		.q_o   (carry_q),
		.tap_o ()
	);

	// ==========================================================
	// Pre-adder and multiplier
	always_comb
	begin
		if (ctl[CTL_PRESEL]) // preadd_operand_select
			pre_op = {{9{b_q[17]}}, b_q};
		else
			pre_op = {{2{a_q[24]}}, a_q[24:0]};
		if (inmode_q[PREADD_BIT])
			next_ad = {{2{d_q[24]}}, d_q} - pre_op;
		else
			next_ad = {{2{d_q[24]}}, d_q} + pre_op;
	end

	dsp_pipe #(.W(MA_W), .DEPTH(AD_DEPTH)) u_ad
	(
		.clk_i (clk_i),
		.clr_i (rst_i | clr_i.d),
		.ce_i  ({1'b0, ce_i.ad}),
		.d_i   (next_ad),
		.q_o   (ad_q),
		.tap_o ()
	);

	// mult_a_source_select and mult_b_source_select
	assign mult_a = ctl[CTL_AMUX] ? ad_q : a_q[26:0];
	assign mult_b = ctl[CTL_BMUX] ? ad_q[17:0] : b_q;
	assign next_m = USE_MULT ?
		PROD_W'($signed(mult_a) * $signed(mult_b)) : '0;

	dsp_pipe #(.W(PROD_W), .DEPTH(M_DEPTH)) u_m
	(
		.clk_i (clk_i),
		.clr_i (rst_i | clr_i.m),
		.ce_i  ({1'b0, ce_i.m}),
		.d_i   (next_m),
		.q_o   (m_q),
		.tap_o ()
	);

	// ==========================================================
	// SIMD adder: carries stop at every lane start
	function automatic logic [51:0] lane_add(
		input logic [47:0] x,
		input logic [47:0] y,
		input logic [3:0]  lcin,
		input logic [3:0]  brk
	);
		logic [12:0] s;
		logic        c;
		logic [51:0] r;
		c = 1'b0;
		r = '0;
		for (int k = 0; k < LANES; k++)
		begin
			s = {1'b0, x[LANE_W*k +: LANE_W]} +
				{1'b0, y[LANE_W*k +: LANE_W]} +
				{12'h000, brk[k] ? lcin[k] : c};
			r[LANE_W*k +: LANE_W] = s[11:0];
			r[48+k] = s[12];
			c = s[12];
		end
		return r;
	endfunction

	always_comb
	begin
		case (opmode_q[1:0])
			X_PROD:  x_op = {{3{m_q[44]}}, m_q};
			X_P:     x_op = p_o;
			X_AB:    x_op = {a_q, b_q};
			default: x_op = '0;
		endcase
		y_op = (opmode_q[3:2] == Y_C) ? c_q : '0;
		case (opmode_q[6:4])
			Z_PCIN:  z_op = pcin_i;
			Z_P:     z_op = p_o;
			Z_C:     z_op = c_q;
			default: z_op = '0;
		endcase
		cin = (csel_q == CSEL_CARRY_IN) ? carry_q : 1'b0;
		xy  = lane_add(x_op, y_op, BRK & {4{cin}}, BRK);
		case (alu_q)
			ALU_SUB: res = lane_add(z_op, ~xy[47:0], BRK, BRK);
			ALU_XOR: res = {4'h0, z_op ^ x_op};
			ALU_AND: res = {4'h0, z_op & x_op};
			ALU_OR:  res = {4'h0, z_op | x_op};
			default: res = lane_add(z_op, xy[47:0], 4'h0, BRK);
		endcase
	end

	// ==========================================================
	// Pattern detector and result register
	assign pat = PAT_FROM_C ? c_q : PATTERN;

	always_comb
	begin
		case (MASK_SRC)
			MASK_C:      mask = c_q;
			MASK_ROUND1: mask = {~c_q[46:0], 1'b0};
			MASK_ROUND2: mask = {~c_q[45:0], 2'h0};
			default:     mask = MASK;
		endcase
		next_p = {res[51:48] & ENDS,
			((res[47:0] ^ ~pat) & ~mask) == '0,
			((res[47:0] ^ pat) & ~mask) == '0,
			res[47:0]};
	end

	// Detect flag stands beside P, so clearing follows one cycle later
	assign auto_clr = ctl[CTL_AUTO] & pattern_detect_o &
		(ctl[CTL_PRIO] ? ce_i.p : 1'b1);

	dsp_pipe #(.W(54), .DEPTH(P_DEPTH)) u_p
	(
		.clk_i (clk_i),
		.clr_i (rst_i | clr_i.p | auto_clr),
		.ce_i  ({1'b0, ce_i.p}),
		.d_i   (next_p),
		.q_o   (p_grp),
		.tap_o ()
	);

	assign p_o                  = p_grp[47:0];
	assign pcout_o              = p_grp[47:0];
	assign pattern_detect_o     = p_grp[48];
	assign pattern_bar_detect_o = p_grp[49];
	assign carry_out_o          = p_grp[53:50];

	// ==========================================================
	// Wishbone slave: answers one cycle after the request
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wb_dat_o <= '0;
		else if (wb_cyc_i & wb_stb_i & ~wb_ack_o)
			case (wb_adr_i)
				REG_CTRL:   wb_dat_o <= {27'h0, ctl};
				REG_STATUS: wb_dat_o <= {29'h0, mult_misuse_o,
					pattern_bar_detect_o, pattern_detect_o};
				default:    wb_dat_o <= '0;
			endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctl <= CTL_RST;
		else if (wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o &
			wb_sel_i[0] & (wb_adr_i == REG_CTRL))
			ctl <= wb_dat_i[CTL_W-1:0];
	end

	// Sticky misuse flag; a fresh misuse beats a clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			mult_misuse_o <= 1'b0;
		else if (!USE_MULT && opmode_q[1:0] == X_PROD)
			mult_misuse_o <= 1'b1;
		else if (wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o &
			wb_sel_i[0] & (wb_adr_i == REG_STATUS) &
			wb_dat_i[ST_MISUSE])
			mult_misuse_o <= 1'b0;
	end

	// ==========================================================
	// Checks
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_clear_a: assert property (
		(A_DEPTH > 0) && clr_i.a |=> a_q == '0)
		else $error("A register not cleared");

	c_clear_a: assert property (
		(C_DEPTH > 0) && clr_i.c |=> c_q == '0)
		else $error("C register not cleared");

	p_clear_a: assert property (
		(P_DEPTH > 0) && clr_i.p |=> p_o == '0 && !pattern_detect_o)
		else $error("result not cleared");

	ctrl_clear_a: assert property (
		(OPMODE_DEPTH > 0) && (CSEL_DEPTH > 0) && clr_i.ctrl
		|=> opmode_q == '0 && csel_q == '0)
		else $error("control registers not cleared");

	auto_clear_a: assert property (
		(P_DEPTH > 0) && ctl[CTL_AUTO] && !ctl[CTL_PRIO] &&
		pattern_detect_o |=> p_o == '0)
		else $error("auto clear missed");

	cep_priority_a: assert property (
		(P_DEPTH > 0) && ctl[CTL_AUTO] && ctl[CTL_PRIO] &&
		!ce_i.p && !clr_i.p |=> $stable(p_o))
		else $error("auto clear ignored enable priority");

	b_stage_hold_a: assert property (
		(B_DEPTH == 2) && !ce_i.b_second_stage_enable && !clr_i.b
		|=> $stable(b_q))
		else $error("B second stage moved without enable");

	no_mult_a: assert property (
		!(!USE_MULT && opmode_q[1:0] == X_PROD))
		else $error("multiplier used but not present");

	pattern_a: assert property (
		(P_DEPTH > 0) && ce_i.p && !clr_i.p && !auto_clr
		|=> pattern_detect_o == $past(next_p[48]))
		else $error("pattern flag wrong");

endmodule

// ==== sim/dsp_nbr_model.sv ====
`timescale 1ns/100ps
// ==========
// Fabric control packing and upstream slice cascade register
module dsp_nbr_model
	import dsp_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        load_i,
	input  wire logic [47:0] val_i,
	input  wire logic [6:0]  op_i,
	input  wire logic [3:0]  alu_i,
	input  wire logic        cin_i,
	input  wire logic        sub_i,
	output logic      [47:0] pcout_o,
	output logic      [19:0] ctrl_o
);
	// Packed by bit position, not by the struct, so a drift shows up
	assign ctrl_o = {1'b0, sub_i, 3'h0, CSEL_CARRY_IN, cin_i, alu_i,
		op_i};

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			pcout_o <= 48'h0;
		else if (load_i)
			pcout_o <= val_i;
	end
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
module testbench
	import dsp_pkg::*;
;
	typedef struct {
		logic [4:0]  ctl;
		logic [29:0] a;
		logic [17:0] b;
		logic [47:0] c;
		logic [24:0] d;
		logic [6:0]  op;
		logic [3:0]  alu;
		logic        cin;
		logic        sub;
		logic [47:0] p;
		logic [1:0]  pd;
		logic [3:0]  co;
	} dsp_row_t;

	logic        clk_i = 1'b0;
	logic        rst_i;
	logic [29:0] a;
	logic [17:0] b;
	logic [47:0] c;
	logic [24:0] d;
	logic [6:0]  op;
	logic [3:0]  alu;
	logic        cin;
	logic        sub;
	dsp_clr_t    clr;
	dsp_ce_t     ce;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [3:0]  adr;
	logic [31:0] wdat;
	logic [31:0] rd;
	logic [3:0]  sel;
	logic        ld;
	logic [47:0] pval;
	logic [3:0]  carry_out_o;
	logic        pattern_bar_detect_o;
	logic        mult_misuse_o;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [47:0] pcin;
	logic [19:0] ctrl_w;
	logic [47:0] p_o;
	logic [47:0] pcout_o;
	logic [29:0] acout_o;
	logic [17:0] bcout_o;
	logic        pattern_detect_o;
	int          failures = 0;
	int          n_checks = 0;
	int          ticks = 0;
	dsp_row_t    rows[14];

	always #20 clk_i = ~clk_i;

	dsp_nbr_model u_dsp_nbr_model (.clk_i(clk_i), .rst_i(rst_i),
		.load_i(ld), .val_i(pval), .op_i(op), .alu_i(alu),
		.cin_i(cin), .sub_i(sub), .pcout_o(pcin), .ctrl_o(ctrl_w));

	// Two A and B stages so the per-stage enables are observable;
	// two 24-bit lanes, and bit 3 masked out of the pattern
	dsp_slice #(.A_DEPTH(2), .B_DEPTH(2), .SIMD(SIMD_TWO24),
		.PATTERN(48'h0000_0000_0006), .MASK(48'h0000_0000_0008))
	u_dsp_slice (.clk_i(clk_i), .rst_i(rst_i), .a_i(a), .b_i(b),
		.c_i(c), .d_i(d), .pcin_i(pcin), .ctrl_i(dsp_ctrl_t'(ctrl_w)),
		.clr_i(clr), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .p_o(p_o),
		.pcout_o(pcout_o), .acout_o(acout_o), .bcout_o(bcout_o),
		.carry_out_o(carry_out_o), .pattern_detect_o(pattern_detect_o),
		.pattern_bar_detect_o(pattern_bar_detect_o),
		.mult_misuse_o(mult_misuse_o));

	// ==========
	// Shared tasks
	task automatic chk(input string nm, input logic [47:0] got, exp);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wb(input logic w, input logic [3:0] ad,
		input logic [31:0] wd);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'h1;
		adr <= ad;
		wdat <= wd;
		// Only the bench timeout ends a wait for the answer
		do
		begin
			@(posedge clk_i);
		end
		while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic put(input dsp_row_t r);
		@(posedge clk_i);
		a <= r.a;
		b <= r.b;
		c <= r.c;
		d <= r.d;
		op <= r.op;
		alu <= r.alu;
		cin <= r.cin;
		sub <= r.sub;
	endtask

	task automatic complete_run();
		if (failures == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Long enough for every scenario; a hang ends here
	always @(posedge clk_i)
	begin
		ticks++;
		if (ticks == 5000)
		begin
			failures++;
			complete_run();
		end
	end

	// ==========
	// Main sequence
	initial
	begin
		rows = '{
			'{5'h00, 30'h3, 18'h2, 48'h0, 25'h0,
				7'h01, ALU_ADD, 1'b0, 1'b0, 48'h6, 2'h1, 4'h0},
			'{5'h00, 30'h1, 18'h5, 48'h10, 25'h0,
				7'h33, ALU_ADD, 1'b0, 1'b0, 48'h40015, 2'h0, 4'h0},
			'{5'h00, 30'h0, 18'h1, 48'h100, 25'h0,
				7'h33, ALU_SUB, 1'b0, 1'b0, 48'hff, 2'h0, 4'ha},
			'{5'h00, 30'h0, 18'hff, 48'hf0, 25'h0,
				7'h33, ALU_XOR, 1'b0, 1'b0, 48'h0f, 2'h0, 4'h0},
			'{5'h00, 30'h0, 18'hff, 48'hf0, 25'h0,
				7'h33, ALU_AND, 1'b0, 1'b0, 48'hf0, 2'h0, 4'h0},
			'{5'h00, 30'h0, 18'hff, 48'hf0, 25'h0,
				7'h33, ALU_OR, 1'b0, 1'b0, 48'hff, 2'h0, 4'h0},
			// Carry in enters both 24-bit lanes
			'{5'h00, 30'h0, 18'h0, 48'h10, 25'h0,
				7'h0c, ALU_ADD, 1'b1, 1'b0, 48'h1000011, 2'h0, 4'h0},
			'{5'h00, 30'h0, 18'h2, 48'h0, 25'h0,
				7'h13, ALU_ADD, 1'b0, 1'b0, 48'h1002, 2'h0, 4'h0},
			'{5'h04, 30'h3, 18'h2, 48'h0, 25'h5,
				7'h01, ALU_ADD, 1'b0, 1'b0, 48'h10, 2'h0, 4'h0},
			'{5'h04, 30'h3, 18'h2, 48'h0, 25'h5,
				7'h01, ALU_ADD, 1'b0, 1'b1, 48'h4, 2'h0, 4'h0},
			'{5'h18, 30'h3, 18'h2, 48'h0, 25'h5,
				7'h01, ALU_ADD, 1'b0, 1'b0, 48'h15, 2'h0, 4'h0},
			'{5'h00, 30'h7, 18'h2, 48'h0, 25'h0,
				7'h01, ALU_ADD, 1'b0, 1'b0, 48'he, 2'h1, 4'h0},
			// Lane 0 overflows, nothing reaches lane 1
			'{5'h00, 30'h0, 18'h1, 48'hffffff, 25'h0,
				7'h33, ALU_ADD, 1'b0, 1'b0, 48'h0, 2'h0, 4'h2},
			'{5'h00, 30'h3fffffff, 18'h3fff9, 48'h0, 25'h0,
				7'h03, ALU_ADD, 1'b0, 1'b0, 48'hffff_ffff_fff9, 2'h2,
				4'h0}};
		rst_i = 1'b1;
		{a, b, c, d, op, alu, cin, sub} = '0;
		clr = '0;
		ce = '1;
		{cyc, stb, we, adr, wdat, sel} = '0;
		ld = 1'b1;
		pval = 48'h1000;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[i])
		begin
			wb(1'b1, REG_CTRL, {27'h0, rows[i].ctl});
			put(rows[i]);
			repeat (8) @(posedge clk_i);
			chk("p", p_o, rows[i].p);
			chk("pcout", pcout_o, rows[i].p);
			chk("pd", {46'h0, pattern_bar_detect_o, pattern_detect_o},
				{46'h0, rows[i].pd});
			chk("co", {44'h0, carry_out_o}, {44'h0, rows[i].co});
		end
		wb(1'b1, REG_CTRL, 32'h0);
		put(rows[0]);
		repeat (8) @(posedge clk_i);
		clr.a <= 1'b1;
		@(posedge clk_i);
		clr.a <= 1'b0;
		@(posedge clk_i);
		chk("acout", {18'h0, acout_o}, 48'h0);
		ce.a_first_stage_enable <= 1'b0;
		a <= 30'h7;
		repeat (4) @(posedge clk_i);
		chk("acout", {18'h0, acout_o}, 48'h3);
		ce.a_first_stage_enable <= 1'b1;
		ce.a_second_stage_enable <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk("acout", {18'h0, acout_o}, 48'h7);
		chk("p", p_o, 48'h6);
		ce <= '1;
		clr.b <= 1'b1;
		@(posedge clk_i);
		clr.b <= 1'b0;
		@(posedge clk_i);
		chk("bcout", {30'h0, bcout_o}, 48'h0);
		repeat (8) @(posedge clk_i);
		chk("p", p_o, 48'he);
		ce.b_second_stage_enable <= 1'b0;
		b <= 18'h3;
		repeat (4) @(posedge clk_i);
		chk("bcout", {30'h0, bcout_o}, 48'h3);
		chk("p", p_o, 48'he);
		ce <= '1;
		b <= 18'h2;
		repeat (8) @(posedge clk_i);
		ce.p <= 1'b0;
		a <= 30'h3;
		repeat (8) @(posedge clk_i);
		chk("p", p_o, 48'he);
		clr.p <= 1'b1;
		@(posedge clk_i);
		clr.p <= 1'b0;
		@(posedge clk_i);
		chk("p", p_o, 48'h0);
		ce.p <= 1'b1;
		repeat (8) @(posedge clk_i);
		wb(1'b1, REG_CTRL, 32'h1);
		do
		begin
			@(posedge clk_i);
		end
		while (pattern_detect_o !== 1'b1);
		@(posedge clk_i);
		chk("p", p_o, 48'h0);
		wb(1'b1, REG_CTRL, 32'h0);
		repeat (8) @(posedge clk_i);
		ce.p <= 1'b0;
		wb(1'b1, REG_CTRL, 32'h3);
		repeat (4) @(posedge clk_i);
		chk("p", p_o, 48'h6);
		wb(1'b0, REG_STATUS, 32'h0);
		chk("status", {16'h0, rd}, 48'h1);
		ce.p <= 1'b1;
		wb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl", {16'h0, rd}, 48'h3);
		wb(1'b0, 4'h8, 32'h0);
		chk("unmapped", {16'h0, rd}, 48'h0);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("p", p_o, 48'h0);
		wb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl", {16'h0, rd}, 48'h0);
		chk("misuse", {47'h0, mult_misuse_o}, 48'h0);
		complete_run();
	end
endmodule
